// *** banked_dm_regs.svh ***
`ifndef BANKED_DM_REGS_SVH
`define BANKED_DM_REGS_SVH

// register offsets in the special function area
`define DM_PORT_A_ADDR     8'h00
`define DM_PTR_A_ADDR      8'h01
`define DM_PORT_B_ADDR     8'h02
`define DM_PTR_B_ADDR      8'h03
`define DM_BANK_ADDR       8'h04
`define DM_EEC_ADDR        8'h40

// bank layout
`define DM_SFR_TOP         8'h60
`define DM_B0_GP_START     8'h60
`define DM_B1_GP_START     8'h80
`define DM_GP0_DEPTH       9'h0a0
`define DM_GP_DEPTH        288

// fields and reset values
`define DM_BANK_BIT        0
`define DM_BANK_RST        1'b0
`define DM_PTR_RST         8'h00
`define DM_ZERO_BYTE       8'h00

// one bit per sfr address 00h..5fh
`define DM_UNUSED_MAP_DEF  96'hfff000000700_3f0022030000
`define DM_RO_MAP_DEF      96'h000000000000_000000000100

// request to read answer, in clock cycles
`define DM_RD_LATENCY      2

`endif

// *** banked_dm_pkg.sv ***
`include "banked_dm_regs.svh"

package banked_dm_pkg;

  typedef enum logic [3:0] {
    CLS_ZERO = 4'b0001,
    CLS_OWN  = 4'b0010,
    CLS_GP   = 4'b0100,
    CLS_EXT  = 4'b1000
  } access_cls_t;

  function automatic logic is_gp(input logic bank, input logic [7:0] addr);
    is_gp = bank ? (addr >= `DM_B1_GP_START) : (addr >= `DM_B0_GP_START);
  endfunction

  function automatic logic [8:0] gp_index(input logic bank, input logic [7:0] addr);
    if (bank) begin
      gp_index = 9'(addr - `DM_B1_GP_START) + `DM_GP0_DEPTH;
    end else begin
      gp_index = 9'(addr - `DM_B0_GP_START);
    end
  endfunction

  function automatic logic sfr_flag(input logic [95:0] map, input logic [7:0] addr);
    sfr_flag = (addr < `DM_SFR_TOP) ? map[addr[6:0]] : 1'b0;
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] mask);
    merge_byte = (old_v & ~mask) | (new_v & mask);
  endfunction

endpackage

// *** dm_addr_resolve.sv ***
`timescale 1ns/10ps
`include "banked_dm_regs.svh"

module dm_addr_resolve
  import banked_dm_pkg::*;
#(
  parameter logic [95:0] UNUSED_MAP = `DM_UNUSED_MAP_DEF
) (
  input  wire logic  [7:0] addr_i,
  input  wire logic  [7:0] mp_a_i,
  input  wire logic  [7:0] mp_b_i,
  input  wire logic        bank_i,
  output logic       [7:0] eff_addr_o,
  output logic             eff_bank_o,
  output logic             indirect_o,
  output access_cls_t      cls_o
);

  always_comb begin
    eff_addr_o = addr_i;
    eff_bank_o = 1'b0;
    indirect_o = 1'b0;
    if (addr_i == `DM_PORT_A_ADDR) begin
      eff_addr_o = mp_a_i;
      indirect_o = 1'b1;
    end else if (addr_i == `DM_PORT_B_ADDR) begin
      eff_addr_o = mp_b_i;
      eff_bank_o = bank_i;
      indirect_o = 1'b1;
    end
    cls_o = CLS_EXT;
    if (indirect_o && (eff_addr_o == `DM_PORT_A_ADDR || eff_addr_o == `DM_PORT_B_ADDR)) begin
      cls_o = CLS_ZERO;
    end else if (is_gp(eff_bank_o, eff_addr_o)) begin
      cls_o = CLS_GP;
    end else if (eff_bank_o && eff_addr_o >= `DM_SFR_TOP) begin
      cls_o = CLS_ZERO;
    end else if (eff_addr_o == `DM_PTR_A_ADDR || eff_addr_o == `DM_PTR_B_ADDR
                 || eff_addr_o == `DM_BANK_ADDR) begin
      cls_o = CLS_OWN;
    end else if (sfr_flag(UNUSED_MAP, eff_addr_o)) begin
      cls_o = CLS_ZERO;
    end
  end

endmodule // dm_addr_resolve

// *** dm_gp_ram.sv ***
`timescale 1ns/10ps
`include "banked_dm_regs.svh"

module dm_gp_ram
  import banked_dm_pkg::*;
#(
  parameter int DEPTH = `DM_GP_DEPTH,
  parameter int WIDTH = 8
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] idx_i,
  input  wire logic [WIDTH-1:0]         wdata_i,
  input  wire logic [WIDTH-1:0]         wmask_i,
  output logic      [WIDTH-1:0]         rdata_o
);

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];

  assign rdata_o = mem_reg[idx_i];

  // masked write keeps untouched bits for bit set and clear
  always_comb begin
    mem_next = mem_reg;
    if (we_i) begin
      mem_next[idx_i] = merge_byte(mem_reg[idx_i], wdata_i, wmask_i);
    end
  end

  // volatile storage, no reset
  always_ff @(posedge clk_sys_i) begin
    mem_reg <= mem_next;
  end

endmodule // dm_gp_ram

// *** banked_data_memory_map.sv ***
`timescale 1ns/10ps
`include "banked_dm_regs.svh"

module banked_data_memory_map
  import banked_dm_pkg::*;
#(
  parameter logic [95:0] UNUSED_MAP = `DM_UNUSED_MAP_DEF,
  parameter logic [95:0] RO_MAP     = `DM_RO_MAP_DEF
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       soft_reset_i,
  input  wire logic       wdt_pd_reset_i,
  input  wire logic       req_rd_i,
  input  wire logic       req_wr_i,
  input  wire logic [7:0] req_addr_i,
  input  wire logic [7:0] req_wdata_i,
  input  wire logic       bit_op_i,
  input  wire logic [2:0] bit_idx_i,
  input  wire logic       bit_val_i,
  input  wire logic [7:0] ext_rdata_i,
  output logic      [7:0] rd_data_o,
  output logic            rd_valid_o,
  output logic            bank_select_o,
  output logic            ext_rd_o,
  output logic            ext_wr_o,
  output logic      [7:0] ext_addr_o,
  output logic            ext_bank_o,
  output logic      [7:0] ext_wdata_o,
  output logic      [7:0] ext_wmask_o
);

  logic [7:0]  memory_pointer_a_reg;
  logic [7:0]  memory_pointer_a_next;
  logic [7:0]  memory_pointer_b_reg;
  logic [7:0]  memory_pointer_b_next;
  logic        bank_select_bit_reg;
  logic        bank_select_bit_next;

  logic [7:0]  eff_addr;
  logic        eff_bank;
  logic        indirect;
  access_cls_t cls;

  logic        rd_take;
  logic        wr_take;
  logic [7:0]  wmask;
  logic [7:0]  wbyte;
  logic [7:0]  own_val;
  logic [7:0]  old_byte;
  logic [7:0]  own_new;
  logic [8:0]  gp_idx;
  logic [7:0]  gp_rdata;

  logic        s1_rd_reg;
  logic        s1_rd_next;
  logic        s1_ext_reg;
  logic        s1_ext_next;
  logic [7:0]  s1_data_reg;
  logic [7:0]  s1_data_next;
  logic        rd_valid_reg;
  logic        rd_valid_next;
  logic [7:0]  rd_data_reg;
  logic [7:0]  rd_data_next;

  logic        ext_rd_reg;
  logic        ext_rd_next;
  logic        ext_wr_reg;
  logic        ext_wr_next;
  logic [7:0]  ext_addr_reg;
  logic [7:0]  ext_addr_next;
  logic        ext_bank_reg;
  logic        ext_bank_next;
  logic [7:0]  ext_wdata_reg;
  logic [7:0]  ext_wdata_next;
  logic [7:0]  ext_wmask_reg;
  logic [7:0]  ext_wmask_next;

  // write wins if both strobes are raised
  assign rd_take = req_rd_i && !req_wr_i;
  assign wr_take = req_wr_i;

  dm_addr_resolve #(
    .UNUSED_MAP (UNUSED_MAP)
  ) u_resolve (
    .addr_i     (req_addr_i),
    .mp_a_i     (memory_pointer_a_reg),
    .mp_b_i     (memory_pointer_b_reg),
    .bank_i     (bank_select_bit_reg),
    .eff_addr_o (eff_addr),
    .eff_bank_o (eff_bank),
    .indirect_o (indirect),
    .cls_o      (cls)
  );

  assign gp_idx = gp_index(eff_bank, eff_addr);

  dm_gp_ram #(
    .DEPTH (`DM_GP_DEPTH),
    .WIDTH (8)
  ) u_gp_ram (
    .clk_sys_i (clk_sys_i),
    .we_i      (wr_take && cls == CLS_GP),
    .idx_i     (gp_idx),
    .wdata_i   (wbyte),
    .wmask_i   (wmask),
    .rdata_o   (gp_rdata)
  );

  // bit operations turn into a one-bit write mask
  assign wmask = bit_op_i ? (8'h01 << bit_idx_i) : 8'hff;
  assign wbyte = bit_op_i ? {8{bit_val_i}} : req_wdata_i;

  always_comb begin
    case (eff_addr)
      `DM_PTR_A_ADDR: own_val = memory_pointer_a_reg;
      `DM_PTR_B_ADDR: own_val = memory_pointer_b_reg;
      `DM_BANK_ADDR:  own_val = {7'h00, bank_select_bit_reg};
      default:        own_val = `DM_ZERO_BYTE;
    endcase
  end

  always_comb begin
    case (cls)
      CLS_OWN: old_byte = own_val;
      CLS_GP:  old_byte = gp_rdata;
      default: old_byte = `DM_ZERO_BYTE;
    endcase
  end

  assign own_new = merge_byte(own_val, wbyte, wmask);

  // pointers and bank select
  always_comb begin
    memory_pointer_a_next = memory_pointer_a_reg;
    memory_pointer_b_next = memory_pointer_b_reg;
    bank_select_bit_next  = bank_select_bit_reg;
    if (wr_take && cls == CLS_OWN) begin
      case (eff_addr)
        `DM_PTR_A_ADDR: memory_pointer_a_next = own_new;
        `DM_PTR_B_ADDR: memory_pointer_b_next = own_new;
        `DM_BANK_ADDR:  bank_select_bit_next = own_new[`DM_BANK_BIT];
        default:        bank_select_bit_next = bank_select_bit_reg;
      endcase
    end
    if (soft_reset_i && !wdt_pd_reset_i) begin
      bank_select_bit_next = `DM_BANK_RST;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      memory_pointer_a_reg <= `DM_PTR_RST;
      memory_pointer_b_reg <= `DM_PTR_RST;
      bank_select_bit_reg  <= `DM_BANK_RST;
    end else begin
      memory_pointer_a_reg <= memory_pointer_a_next;
      memory_pointer_b_reg <= memory_pointer_b_next;
      bank_select_bit_reg  <= bank_select_bit_next;
    end
  end

  // read pipeline and peripheral sfr port
  always_comb begin
    s1_rd_next     = rd_take;
    s1_ext_next    = rd_take && cls == CLS_EXT;
    s1_data_next   = old_byte;
    rd_valid_next  = s1_rd_reg;
    rd_data_next   = rd_data_reg;
    if (s1_ext_reg) begin
      rd_data_next = ext_rdata_i;
    end else if (s1_rd_reg) begin
      rd_data_next = s1_data_reg;
    end
    ext_rd_next    = rd_take && cls == CLS_EXT;
    ext_wr_next    = wr_take && cls == CLS_EXT && !sfr_flag(RO_MAP, eff_addr);
    ext_addr_next  = ext_addr_reg;
    ext_bank_next  = ext_bank_reg;
    ext_wdata_next = ext_wdata_reg;
    ext_wmask_next = ext_wmask_reg;
    if ((rd_take || wr_take) && cls == CLS_EXT) begin
      ext_addr_next  = eff_addr;
      ext_bank_next  = eff_bank && eff_addr == `DM_EEC_ADDR;
      ext_wdata_next = wbyte;
      ext_wmask_next = wmask;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s1_rd_reg     <= 1'b0;
      s1_ext_reg    <= 1'b0;
      s1_data_reg   <= `DM_ZERO_BYTE;
      rd_valid_reg  <= 1'b0;
      rd_data_reg   <= `DM_ZERO_BYTE;
      ext_rd_reg    <= 1'b0;
      ext_wr_reg    <= 1'b0;
      ext_addr_reg  <= `DM_ZERO_BYTE;
      ext_bank_reg  <= 1'b0;
      ext_wdata_reg <= `DM_ZERO_BYTE;
      ext_wmask_reg <= `DM_ZERO_BYTE;
    end else begin
      s1_rd_reg     <= s1_rd_next;
      s1_ext_reg    <= s1_ext_next;
      s1_data_reg   <= s1_data_next;
      rd_valid_reg  <= rd_valid_next;
      rd_data_reg   <= rd_data_next;
      ext_rd_reg    <= ext_rd_next;
      ext_wr_reg    <= ext_wr_next;
      ext_addr_reg  <= ext_addr_next;
      ext_bank_reg  <= ext_bank_next;
      ext_wdata_reg <= ext_wdata_next;
      ext_wmask_reg <= ext_wmask_next;
    end
  end

  assign rd_data_o     = rd_data_reg;
  assign rd_valid_o    = rd_valid_reg;
  assign bank_select_o = bank_select_bit_reg;
  assign ext_rd_o      = ext_rd_reg;
  assign ext_wr_o      = ext_wr_reg;
  assign ext_addr_o    = ext_addr_reg;
  assign ext_bank_o    = ext_bank_reg;
  assign ext_wdata_o   = ext_wdata_reg;
  assign ext_wmask_o   = ext_wmask_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  property p_rd_latency;
    rd_take |-> ##1 (rd_valid_o == $past(rd_take, 2)) ##1 rd_valid_o;
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read answer not at cycle 2");

  property p_zero_read;
    rd_take && cls == CLS_ZERO |-> ##2 rd_data_o == 8'h00;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("unused read not zero");

  property p_void_write;
    wr_take && cls == CLS_ZERO && !soft_reset_i |=>
      $stable(memory_pointer_a_reg) && $stable(memory_pointer_b_reg)
      && $stable(bank_select_bit_reg) && !ext_wr_o;
  endproperty
  a_void_write: assert property (p_void_write) else $error("void write changed state");

  property p_bank_upper;
    rd_take && cls == CLS_OWN && eff_addr == `DM_BANK_ADDR |->
      ##2 rd_valid_o && rd_data_o == {7'h00, $past(bank_select_o, 2)};
  endproperty
  a_bank_upper: assert property (p_bank_upper) else $error("bank select upper bits set");

  property p_bank_soft_rst;
    soft_reset_i && !wdt_pd_reset_i |=> !bank_select_o;
  endproperty
  a_bank_soft_rst: assert property (p_bank_soft_rst) else $error("bank not cleared");

  property p_bank_wdt_hold;
    soft_reset_i && wdt_pd_reset_i && !(wr_take && cls == CLS_OWN) |=> $stable(bank_select_o);
  endproperty
  a_bank_wdt_hold: assert property (p_bank_wdt_hold) else $error("bank lost on wdt");

  property p_direct_bank0;
    !indirect && cls == CLS_GP |-> gp_idx < `DM_GP0_DEPTH;
  endproperty
  a_direct_bank0: assert property (p_direct_bank0) else $error("direct access left bank 0");

  property p_port_a_bank0;
    req_addr_i == `DM_PORT_A_ADDR |-> !eff_bank && eff_addr == memory_pointer_a_reg;
  endproperty
  a_port_a_bank0: assert property (p_port_a_bank0) else $error("pair a left bank 0");

  property p_ro_write;
    wr_take && cls == CLS_EXT && sfr_flag(RO_MAP, eff_addr) |=> !ext_wr_o;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only sfr written");

  property p_ptr_write;
    wr_take && !bit_op_i && cls == CLS_OWN && eff_addr == `DM_PTR_A_ADDR |=>
      memory_pointer_a_reg == $past(req_wdata_i);
  endproperty
  a_ptr_write: assert property (p_ptr_write) else $error("pointer a not written");

  property p_eec_bank;
    (rd_take || wr_take) && cls == CLS_EXT && eff_addr == `DM_EEC_ADDR |=>
      ext_bank_o == $past(eff_bank) && ext_addr_o == `DM_EEC_ADDR;
  endproperty
  a_eec_bank: assert property (p_eec_bank) else $error("40h bank flag wrong");

endmodule // banked_data_memory_map

// *** sfr_periph_model.sv ***
`timescale 1ns/10ps

module sfr_periph_model (
  input  wire logic       clk_sys_i,
  input  wire logic       ext_rd_i,
  input  wire logic       ext_wr_i,
  input  wire logic [7:0] ext_addr_i,
  input  wire logic       ext_bank_i,
  input  wire logic [7:0] ext_wdata_i,
  input  wire logic [7:0] ext_wmask_i,
  output logic      [7:0] ext_rdata_o
);
  logic [7:0] regs [0:511];
  logic [7:0] last_q;
  logic [8:0] idx;

  // arbitrary power-up contents, never zero below 60h
  initial begin
    for (int i = 0; i < 512; i++) begin
      regs[i] = i[7:0] ^ 8'ha5;
    end
    last_q = 8'h00;
  end

  assign idx = {ext_bank_i, ext_addr_i};

  // masked store covers bit operations on peripheral registers
  always @(posedge clk_sys_i) begin
    if (ext_wr_i === 1'b1) begin
      regs[idx] <= (regs[idx] & ~ext_wmask_i) | (ext_wdata_i & ext_wmask_i);
    end
    if (ext_rd_i === 1'b1) begin
      last_q <= ext_rdata_o;
    end
  end

  // released bus shows the inverse of the last byte
  assign ext_rdata_o = (ext_rd_i === 1'b1) ? regs[idx] : ~last_q;
endmodule // sfr_periph_model

// *** tb_banked_data_memory_map.sv ***
`timescale 1ns/10ps

module tb_banked_data_memory_map;
  logic       clk_sys_i = 1'b0;
  logic       reset_i, soft_reset_i, wdt_pd_reset_i;
  logic       req_rd_i, req_wr_i, bit_op_i, bit_val_i;
  logic [2:0] bit_idx_i;
  logic [7:0] req_addr_i, req_wdata_i, ext_rdata_i, rd_data_o;
  logic [7:0] ext_addr_o, ext_wdata_o, ext_wmask_o;
  logic       rd_valid_o, bank_select_o, ext_rd_o, ext_wr_o, ext_bank_o;
  logic [7:0] mem [0:511];
  logic [7:0] exp_q [$];
  logic [7:0] pa, pb, a, d;
  logic [7:0] unused_a [10] = '{8'h10, 8'h11, 8'h19, 8'h1d, 8'h28,
                               8'h2d, 8'h38, 8'h3a, 8'h54, 8'h5f};
  logic       bk;
  logic [31:0] r;
  int         errors, n_checks, seed, i;

  always #2 clk_sys_i = ~clk_sys_i;

  banked_data_memory_map banked_data_memory_map_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .soft_reset_i(soft_reset_i),
    .wdt_pd_reset_i(wdt_pd_reset_i), .req_rd_i(req_rd_i), .req_wr_i(req_wr_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .bit_op_i(bit_op_i),
    .bit_idx_i(bit_idx_i), .bit_val_i(bit_val_i), .ext_rdata_i(ext_rdata_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .bank_select_o(bank_select_o),
    .ext_rd_o(ext_rd_o), .ext_wr_o(ext_wr_o), .ext_addr_o(ext_addr_o),
    .ext_bank_o(ext_bank_o), .ext_wdata_o(ext_wdata_o), .ext_wmask_o(ext_wmask_o));

  sfr_periph_model sfr_periph_model_i (
    .clk_sys_i(clk_sys_i), .ext_rd_i(ext_rd_o), .ext_wr_i(ext_wr_o),
    .ext_addr_i(ext_addr_o), .ext_bank_i(ext_bank_o), .ext_wdata_i(ext_wdata_o),
    .ext_wmask_i(ext_wmask_o), .ext_rdata_o(ext_rdata_i));

  task automatic check(input logic [7:0] e, input logic [7:0] s, input string what);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one request per call, lasting one cycle from a falling edge
  task automatic op(input logic rq, input logic wq, input logic [7:0] ad,
                    input logic [7:0] wd, input logic bo, input logic [2:0] bi,
                    input logic bv);
    req_rd_i = rq;
    req_wr_i = wq;
    req_addr_i = ad;
    req_wdata_i = wd;
    bit_op_i = bo;
    bit_idx_i = bi;
    bit_val_i = bv;
    @(negedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    op(1'b0, 1'b1, ad, wd, 1'b0, 3'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    op(1'b1, 1'b0, ad, 8'h00, 1'b0, 3'h0, 1'b0);
  endtask

  task automatic idle;
    op(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 3'h0, 1'b0);
  endtask

  // each answer is matched to the oldest outstanding read
  always @(negedge clk_sys_i) begin
    if (rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("unexpected rd_valid_o: expected 0 seen 1");
      end else begin
        check(exp_q.pop_front(), rd_data_o, "rd_data_o");
      end
    end
  end

  initial begin
    repeat (8000) @(posedge clk_sys_i);
    errors++;
    $display("unexpected run length: expected end seen timeout");
    test_done;
  end

  initial begin
    seed = 59225;
    reset_i = 1'b1;
    soft_reset_i = 1'b0;
    wdt_pd_reset_i = 1'b0;
    req_rd_i = 1'b0;
    req_wr_i = 1'b0;
    req_addr_i = 8'h00;
    req_wdata_i = 8'h00;
    bit_op_i = 1'b0;
    bit_idx_i = 3'h0;
    bit_val_i = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    reset_i = 1'b0;
    check(8'h00, {7'h00, bank_select_o}, "bank_select_o");
    rd(8'h04, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h00);
    wr(8'h04, 8'hfe);
    rd(8'h04, 8'h00);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h01);
    check(8'h01, {7'h00, bank_select_o}, "bank_select_o");
    // fill both banks so that every later read has a known value
    for (i = 8'h80; i < 256; i++) begin
      d = 8'($random(seed));
      wr(8'h03, i[7:0]);
      wr(8'h02, d);
      mem[{1'b1, i[7:0]}] = d;
    end
    for (i = 8'h60; i < 256; i++) begin
      d = 8'($random(seed));
      wr(i[7:0], d);
      mem[{1'b0, i[7:0]}] = d;
    end
    idle();
    soft_reset_i = 1'b1;
    wdt_pd_reset_i = 1'b1;
    @(negedge clk_sys_i);
    soft_reset_i = 1'b0;
    check(8'h01, {7'h00, bank_select_o}, "bank_select_o");
    @(negedge clk_sys_i);
    soft_reset_i = 1'b1;
    wdt_pd_reset_i = 1'b0;
    @(negedge clk_sys_i);
    soft_reset_i = 1'b0;
    check(8'h00, {7'h00, bank_select_o}, "bank_select_o");
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    wr(8'h03, 8'h02);
    rd(8'h02, 8'h00);
    wr(8'h04, 8'h01);
    for (i = 0; i < 2; i++) begin
      wr(8'h03, i[0] ? 8'h7f : 8'h60);
      wr(8'h02, 8'h3c);
      rd(8'h02, 8'h00);
    end
    wr(8'h03, 8'h40);
    wr(8'h02, 8'h11);
    rd(8'h02, 8'h11);
    rd(8'h40, 8'he5);
    wr(8'h03, 8'h08);
    rd(8'h02, 8'had);
    wr(8'h03, 8'h40);
    wr(8'h04, 8'h00);
    rd(8'h02, 8'he5);
    wr(8'h20, 8'h3c);
    op(1'b0, 1'b1, 8'h20, 8'h00, 1'b1, 3'h7, 1'b1);
    rd(8'h20, 8'hbc);
    wr(8'h08, 8'h00);
    rd(8'h08, 8'had);
    foreach (unused_a[k]) begin
      wr(unused_a[k], 8'hff);
      rd(unused_a[k], 8'h00);
    end
    op(1'b0, 1'b1, 8'h01, 8'h00, 1'b1, 3'h0, 1'b1);
    rd(8'h01, 8'h01);
    wr(8'h01, 8'h60);
    wr(8'h03, 8'h80);
    pa = 8'h60;
    pb = 8'h80;
    bk = 1'b0;
    // random back-to-back mix against a reference of both banks
    for (i = 0; i < 1500; i++) begin
      r = $random(seed);
      a = 8'h60 + (r[7:0] % 8'ha0);
      d = r[15:8];
      case (r[18:16])
        3'd0: begin
          wr(a, d);
          mem[{1'b0, a}] = d;
        end
        3'd1: rd(a, mem[{1'b0, a}]);
        3'd2: begin
          wr(8'h01, a);
          pa = a;
        end
        3'd3: begin
          pb = a | 8'h80;
          wr(8'h03, pb);
        end
        3'd4: begin
          wr(8'h04, d);
          bk = d[0];
        end
        3'd5: begin
          if (r[19]) wr(8'h00, d);
          if (r[19]) mem[{1'b0, pa}] = d;
          else rd(8'h00, mem[{1'b0, pa}]);
        end
        3'd6: begin
          if (r[19]) wr(8'h02, d);
          if (r[19]) mem[{bk, pb}] = d;
          else rd(8'h02, mem[{bk, pb}]);
        end
        default: begin
          op(1'b0, 1'b1, a, 8'h00, 1'b1, r[21:19], r[22]);
          mem[{1'b0, a}][r[21:19]] = r[22];
        end
      endcase
    end
    idle();
    for (i = 0; i < 8 && exp_q.size() > 0; i++) @(negedge clk_sys_i);
    if (exp_q.size() != 0) begin
      errors++;
      $display("unexpected pending reads: expected 0 seen %0d", exp_q.size());
    end
    test_done;
  end
endmodule // tb_banked_data_memory_map
